/* cpf_pkg.sv */
// Purpose: Shared types and constants for the cell protection fault logic
// Assumes: 50 MHz system clock, 10 kHz delay tick derived from it
// Notes:   All delay counts are in ticks of the 10 kHz time base
//
// How it works
// RQ1: Charge overcurrent delay is strapped as 4, 6, 8 or 16 ms.
// RQ2: Load short delay is fixed at 250 us, no strap.
// RQ3: A detected fault runs its delay timer, then drops its FET gate.
// RQ4: A released fault runs a recovery timer; gate returns if undisturbed.
// RQ5: Normal mode drives both gate enables on.
// RQ6: Cell above overcharge threshold past its delay drops the charge gate.
// RQ7: Overcharge with sense above charge limit releases below release level.
// RQ8: Overcharge with load present releases below the overcharge threshold.
// RQ9: Charger still present keeps overcharge until sense passes discharge limit.
// RQ10: Discharge overcurrent and short detection off while cell over threshold; the code blinds them so only in overcharge mode, not in normal mode.
// RQ11: Cell below over-discharge threshold past its delay drops discharge gate.
// RQ12: Over-discharge pulls sense up, sink off, power-down within 1.3 V.
// RQ13: Charger with sense below -0.7 V releases above over-discharge threshold.
// RQ14: Charger with sense above -0.7 V needs the release level too.
// RQ15: Discharge overcurrent past delay drops discharge gate, sink on, pull-up off.
// RQ16: Discharge overcurrent ends once sense is 1 V or more below the cell.
// RQ17: Charge overcurrent past delay drops charge gate until sense returns.
// RQ18: No charge overcurrent check in over-discharge; both sense paths off in it.
// RQ19: Zero-volt charging runs with charge overcurrent check overridden.
// RQ20: Below the inhibit level the charge gate is held off.
// RQ21: All delay timers count a 10 kHz internal tick.
// RQ22: Short above its threshold trips on its shorter delay.
// RQ23: Overcharge delay is strapped as 0.25, 1.00, 1.25 or 4.50 s.
// RQ24: Over-discharge delay is strapped as 20, 96, 125 or 144 ms.
// RQ25: Discharge overcurrent delay is strapped as 8, 16, 20 or 48 ms.
// RQ26: Timers count ticks while true and clear when the condition drops.

package cpf_pkg;

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  localparam int CLK_HZ       = 50_000_000;
  localparam int TICK_HZ      = 10_000;
  localparam int TICK_DIV_DEF = CLK_HZ / TICK_HZ;
  localparam int US_PER_TICK  = 1_000_000 / TICK_HZ;
  localparam int DIV_W        = 13;
  localparam int CNT_W        = 16;

  // ----------------------------------------------------------------
  // Delay options in microseconds
  // ----------------------------------------------------------------
  localparam int OVPD_US [4] = '{250_000, 1_000_000, 1_250_000, 4_500_000};
  localparam int UVPD_US [4] = '{20_000, 96_000, 125_000, 144_000};
  localparam int OCDD_US [4] = '{8_000, 16_000, 20_000, 48_000};
  localparam int OCCD_US [4] = '{4_000, 6_000, 8_000, 16_000};
  localparam int SCCD_US     = 250;
  localparam int REC_US      = 2_000;

  // Least times round up to whole ticks
  function automatic logic [CNT_W-1:0] to_ticks(input int us);
    return CNT_W'((us + US_PER_TICK - 1) / US_PER_TICK);
  endfunction

  // ----------------------------------------------------------------
  // Timer channels and modes
  // ----------------------------------------------------------------
  localparam int CH_OVP = 0;
  localparam int CH_UVP = 1;
  localparam int CH_OCD = 2;
  localparam int CH_SCC = 3;
  localparam int CH_OCC = 4;
  localparam int CH_REC = 5;
  localparam int NCH    = 6;

  typedef enum logic [2:0] {
    MODE_NORMAL, MODE_OVERCHARGE, MODE_OVER_DISCH,
    MODE_DISCH_OC, MODE_CHARGE_OC
  } cpf_mode_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cell_above_ovp;  logic cell_above_ovp_rel;
    logic cell_below_uvp;  logic cell_above_uvp_rel;
    logic cell_below_inh;  logic sense_ge_ocd;
    logic sense_ge_scc;    logic sense_below_occ;
    logic sense_far;       logic sense_below_neg;
    logic sense_le_cell_m1v;
  } cpf_cmp_t;

  typedef struct packed {
    logic [1:0] ovp_sel; logic [1:0] uvp_sel;
    logic [1:0] ocd_sel; logic [1:0] occ_sel;
  } cpf_strap_t;

  typedef struct packed {
    logic charge_gate_drive;  logic discharge_gate_drive;
    logic sense_pullup_en;    logic sense_sink_en;
    logic power_down;
  } cpf_drive_t;

  typedef struct packed {
    logic overcharge_fault;   logic over_discharge_fault;
    logic discharge_overcurrent_fault;
    logic load_short_fault;   logic charge_overcurrent_fault;
    logic zero_volt_charging;
  } cpf_flags_t;

  localparam int CMP_W   = $bits(cpf_cmp_t);
  localparam int STRAP_W = $bits(cpf_strap_t);

endpackage

/* cpf_sync.sv */
// Purpose: Two-stage synchroniser for asynchronous comparator levels
// Assumes: Inputs are slow levels, not pulses
// Notes:   No reset; first stage feeds only the second stage
`timescale 1ns/1ns

module cpf_sync #(
  parameter int W = 8
) (
  // Clock
  input  wire logic         sys_clk,
  // Levels in and out
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } cpf_sync_t;

  cpf_sync_t s;
  cpf_sync_t next_s;

  // Shift one stage per edge
  always_comb begin
    next_s.s1 = d;
    next_s.s2 = s.s1;
  end

  always_ff @(posedge sys_clk) begin
    s <= next_s;
  end

  assign q = s.s2;

endmodule

/* cpf_delay_timer.sv */
// Purpose: One delay timer counting 10 kHz ticks while its condition holds
// Assumes: tick is a one-cycle pulse on sys_clk
// Notes:   done rises in the same cycle as the count reaches limit
`timescale 1ns/1ns

module cpf_delay_timer (
  // Clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    reset,
  // Control
  input  wire logic                    tick,
  input  wire logic                    cond,
  input  wire logic                    clr,
  input  wire logic [cpf_pkg::CNT_W-1:0] limit,
  // Result
  output var  logic                    done
);

  typedef struct packed {
    logic [cpf_pkg::CNT_W-1:0] cnt;
    logic                      done;
  } cpf_tmr_t;

  cpf_tmr_t s;
  cpf_tmr_t next_s;

  // Count while true, restart on any drop
  always_comb begin
    next_s = s;
    if (clr || !cond) begin
      next_s.cnt = '0;                                   // RQ26
    end else if (tick && (s.cnt < limit)) begin
      next_s.cnt = s.cnt + 1'b1;                         // RQ21
    end
    next_s.done = cond && !clr && (next_s.cnt >= limit); // RQ3
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done = s.done;

  a_done_needs_cond: assert property (@(posedge sys_clk) // RQ26
    disable iff (reset) s.done |-> $past(cond))
    else $error("timer done without condition");
  a_drop_clears: assert property (@(posedge sys_clk) // RQ26
    disable iff (reset) !cond |=> (s.cnt == '0) && !s.done)
    else $error("timer not cleared");

endmodule

/* cpf_fault_fsm.sv */
// Purpose: Fault detection and recovery for a single-cell protector
// Assumes: Comparator and strap inputs arrive asynchronously
// Notes:   Straps are caught while reset is held
`timescale 1ns/1ns

module cpf_fault_fsm #(
  parameter int TICK_DIV = cpf_pkg::TICK_DIV_DEF
) (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                reset,
  // Comparator results and factory straps
  input  wire cpf_pkg::cpf_cmp_t   cmp,
  input  wire cpf_pkg::cpf_strap_t strap,
  // FET gates and sense pin control
  output var  cpf_pkg::cpf_drive_t drive,
  // Fault status
  output var  cpf_pkg::cpf_flags_t flags
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    cpf_pkg::cpf_mode_t          mode;
    logic [cpf_pkg::DIV_W-1:0]   div;
    logic                        tick;
    cpf_pkg::cpf_strap_t         strap;
    cpf_pkg::cpf_drive_t         drive;
    cpf_pkg::cpf_flags_t         flags;
  } cpf_fsm_t;

  cpf_fsm_t s;
  cpf_fsm_t next_s;

  localparam logic [cpf_pkg::DIV_W-1:0] DIV_LAST =
    cpf_pkg::DIV_W'(TICK_DIV - 1);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [cpf_pkg::CMP_W+cpf_pkg::STRAP_W-1:0] sync_q;
  cpf_pkg::cpf_cmp_t                          c;
  cpf_pkg::cpf_strap_t                        strap_s;

  cpf_sync #(
    .W (cpf_pkg::CMP_W + cpf_pkg::STRAP_W)
  ) u_sync (
    .sys_clk (sys_clk),
    .d       ({cmp, strap}),
    .q       (sync_q)
  );

  // Split the synchronised word back into its carriers
  assign c       = sync_q[cpf_pkg::CMP_W+cpf_pkg::STRAP_W-1:
                          cpf_pkg::STRAP_W];
  assign strap_s = sync_q[cpf_pkg::STRAP_W-1:0];

  // ----------------------------------------------------------------
  // Timer conditions, limits and clear
  // ----------------------------------------------------------------
  logic [cpf_pkg::NCH-1:0]   tcond;
  logic [cpf_pkg::NCH-1:0]   tdone;
  logic [cpf_pkg::CNT_W-1:0] lim [cpf_pkg::NCH];
  logic                      mode_chg;
  logic                      normal;
  logic                      ocd_ok;
  logic                      charger;

  // Delay limits; all but short and recovery picked by the straps caught at reset
  always_comb begin
    lim[cpf_pkg::CH_OVP] = cpf_pkg::to_ticks(
      cpf_pkg::OVPD_US[s.strap.ovp_sel]);                // RQ23
    lim[cpf_pkg::CH_UVP] = cpf_pkg::to_ticks(
      cpf_pkg::UVPD_US[s.strap.uvp_sel]);                // RQ24
    lim[cpf_pkg::CH_OCD] = cpf_pkg::to_ticks(
      cpf_pkg::OCDD_US[s.strap.ocd_sel]);                // RQ25
    lim[cpf_pkg::CH_SCC] = cpf_pkg::to_ticks(
      cpf_pkg::SCCD_US);                                 // RQ2
    lim[cpf_pkg::CH_OCC] = cpf_pkg::to_ticks(
      cpf_pkg::OCCD_US[s.strap.occ_sel]);                // RQ1
    lim[cpf_pkg::CH_REC] = cpf_pkg::to_ticks(
      cpf_pkg::REC_US);
  end

  // A charger pulls sense well away from the cell
  assign charger = c.sense_far;
  assign normal  = (s.mode == cpf_pkg::MODE_NORMAL);
  // Load tests stay blind in overcharge while the cell sits over threshold
  assign ocd_ok  = normal ||
                   ((s.mode == cpf_pkg::MODE_OVERCHARGE) &&
                    !c.cell_above_ovp);                  // RQ10

  // Detection and recovery conditions per channel
  always_comb begin
    tcond = '0;
    tcond[cpf_pkg::CH_OVP] = normal && c.cell_above_ovp; // RQ6
    tcond[cpf_pkg::CH_UVP] = normal && c.cell_below_uvp; // RQ11
    tcond[cpf_pkg::CH_OCD] = ocd_ok && c.sense_ge_ocd;   // RQ15
    tcond[cpf_pkg::CH_SCC] = ocd_ok && c.sense_ge_scc;   // RQ22
    // Over-discharge never reaches this, normal gates it
    tcond[cpf_pkg::CH_OCC] = normal &&
                             c.sense_below_occ;          // RQ17 RQ18
    case (s.mode)
      cpf_pkg::MODE_OVERCHARGE: begin
        // Charger present blocks both release paths
        tcond[cpf_pkg::CH_REC] =
          (!c.sense_below_occ && !c.sense_ge_ocd &&
           !c.cell_above_ovp_rel) ||                     // RQ7 RQ9
          (c.sense_ge_ocd && !c.cell_above_ovp);         // RQ8
      end
      cpf_pkg::MODE_OVER_DISCH: begin
        tcond[cpf_pkg::CH_REC] = charger &&
          (c.sense_below_neg ? !c.cell_below_uvp         // RQ13
                             : c.cell_above_uvp_rel);    // RQ14 RQ19
      end
      cpf_pkg::MODE_DISCH_OC: begin
        tcond[cpf_pkg::CH_REC] = c.sense_le_cell_m1v;    // RQ16
      end
      cpf_pkg::MODE_CHARGE_OC: begin
        tcond[cpf_pkg::CH_REC] = !c.sense_below_occ;     // RQ17
      end
      default: begin
        tcond[cpf_pkg::CH_REC] = 1'b0;
      end
    endcase
  end

  // Any mode change restarts every timer from zero
  assign mode_chg = (next_s.mode != s.mode);

  // ----------------------------------------------------------------
  // Delay timers
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < cpf_pkg::NCH; gi++) begin : g_tmr
      cpf_delay_timer u_tmr (
        .sys_clk (sys_clk),
        .reset   (reset),
        .tick    (s.tick),
        .cond    (tcond[gi]),
        .clr     (mode_chg),
        .limit   (lim[gi]),
        .done    (tdone[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    // Free-running 10 kHz time base
    next_s.tick = (s.div == DIV_LAST);                   // RQ21
    next_s.div  = next_s.tick ? '0 : s.div + 1'b1;
    // Short or overcurrent first, then overcharge, over-discharge, charge overcurrent
    case (s.mode)
      cpf_pkg::MODE_NORMAL: begin
        if (tdone[cpf_pkg::CH_SCC] ||
            tdone[cpf_pkg::CH_OCD]) begin
          next_s.mode = cpf_pkg::MODE_DISCH_OC;          // RQ22 RQ15
        end else if (tdone[cpf_pkg::CH_OVP]) begin
          next_s.mode = cpf_pkg::MODE_OVERCHARGE;        // RQ6
        end else if (tdone[cpf_pkg::CH_UVP]) begin
          next_s.mode = cpf_pkg::MODE_OVER_DISCH;        // RQ11
        end else if (tdone[cpf_pkg::CH_OCC]) begin
          next_s.mode = cpf_pkg::MODE_CHARGE_OC;         // RQ17
        end
      end
      cpf_pkg::MODE_OVERCHARGE: begin
        if (tdone[cpf_pkg::CH_SCC] ||
            tdone[cpf_pkg::CH_OCD]) begin
          next_s.mode = cpf_pkg::MODE_DISCH_OC;          // RQ10
        end else if (tdone[cpf_pkg::CH_REC]) begin
          next_s.mode = cpf_pkg::MODE_NORMAL;            // RQ4
        end
      end
      cpf_pkg::MODE_OVER_DISCH,
      cpf_pkg::MODE_DISCH_OC,
      cpf_pkg::MODE_CHARGE_OC: begin
        if (tdone[cpf_pkg::CH_REC]) begin
          next_s.mode = cpf_pkg::MODE_NORMAL;            // RQ4
        end
      end
      default: begin
        next_s.mode = cpf_pkg::MODE_NORMAL;
      end
    endcase

    // Gates and sense control follow the coming mode
    next_s.drive = '0;
    next_s.flags = '0;
    case (next_s.mode)
      cpf_pkg::MODE_NORMAL: begin
        next_s.drive.charge_gate_drive    = 1'b1;        // RQ5
        next_s.drive.discharge_gate_drive = 1'b1;        // RQ5
      end
      cpf_pkg::MODE_OVERCHARGE: begin
        next_s.drive.discharge_gate_drive = 1'b1;
        next_s.flags.overcharge_fault     = 1'b1;        // RQ6
      end
      cpf_pkg::MODE_OVER_DISCH: begin
        // Charging stays open so a charger can lift the cell
        next_s.drive.charge_gate_drive    = 1'b1;        // RQ19
        next_s.drive.sense_pullup_en      = 1'b1;        // RQ12
        next_s.drive.power_down           = !charger;    // RQ12
        next_s.flags.over_discharge_fault = 1'b1;        // RQ11
        next_s.flags.zero_volt_charging   = charger &&
          c.cell_below_uvp;                              // RQ19
      end
      cpf_pkg::MODE_DISCH_OC: begin
        next_s.drive.charge_gate_drive    = 1'b1;
        next_s.drive.sense_sink_en        = 1'b1;        // RQ15
        next_s.flags.discharge_overcurrent_fault = 1'b1;
        // Keep the short flag once taken, or on entry
        next_s.flags.load_short_fault =
          (s.mode == cpf_pkg::MODE_DISCH_OC) ?
          s.flags.load_short_fault : tdone[cpf_pkg::CH_SCC];
      end
      cpf_pkg::MODE_CHARGE_OC: begin
        next_s.drive.discharge_gate_drive = 1'b1;        // RQ18
        next_s.flags.charge_overcurrent_fault = 1'b1;
      end
      default: begin
        next_s.drive = '0;
      end
    endcase
    // Shorted cell: never let charge current in
    if (c.cell_below_inh) begin
      next_s.drive.charge_gate_drive  = 1'b0;            // RQ20
      next_s.flags.zero_volt_charging = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Straps are followed while reset is held, then frozen
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s       <= '0;
      s.mode  <= cpf_pkg::MODE_NORMAL;
      s.strap <= strap_s;
    end else begin
      s <= next_s;
    end
  end

  assign drive = s.drive;
  assign flags = s.flags;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic inh_q;
  logic far_q;
  logic [cpf_pkg::DIV_W-1:0] tick_gap;

  // Helper copies and tick spacing counter; all ones at reset so
  // the first tick after release also lands on DIV_LAST
  always_ff @(posedge sys_clk) begin
    inh_q    <= c.cell_below_inh;
    far_q    <= charger;
    tick_gap <= reset ? '1 : (s.tick ? '0 : tick_gap + 1'b1);
  end

  a_gates_normal: assert property (@(posedge sys_clk) // RQ5
    disable iff (reset)
    !$past(reset) && (s.mode == cpf_pkg::MODE_NORMAL) && !inh_q |->
      drive.charge_gate_drive && drive.discharge_gate_drive)
    else $error("normal mode gate off");

  a_ovp_charge_off: assert property (@(posedge sys_clk) // RQ6
    disable iff (reset)
    (s.mode == cpf_pkg::MODE_OVERCHARGE) |->
      !drive.charge_gate_drive && flags.overcharge_fault)
    else $error("charge gate on in overcharge");

  a_odis_sense: assert property (@(posedge sys_clk) // RQ12
    disable iff (reset)
    (s.mode == cpf_pkg::MODE_OVER_DISCH) |->
      !drive.discharge_gate_drive && drive.sense_pullup_en &&
      !drive.sense_sink_en && (drive.power_down == !far_q))
    else $error("over-discharge sense control wrong");

  a_doc_sink: assert property (@(posedge sys_clk) // RQ15
    disable iff (reset)
    (s.mode == cpf_pkg::MODE_DISCH_OC) |->
      !drive.discharge_gate_drive && drive.sense_sink_en &&
      !drive.sense_pullup_en)
    else $error("discharge overcurrent control wrong");

  a_coc_paths_off: assert property (@(posedge sys_clk) // RQ18
    disable iff (reset)
    (s.mode == cpf_pkg::MODE_CHARGE_OC) |->
      !drive.charge_gate_drive && !drive.sense_sink_en &&
      !drive.sense_pullup_en)
    else $error("charge overcurrent control wrong");

  a_inhibit_gate: assert property (@(posedge sys_clk) // RQ20
    disable iff (reset)
    inh_q |-> !drive.charge_gate_drive)
    else $error("charge gate on below inhibit");

  a_short_fast: assert property (@(posedge sys_clk) // RQ22
    disable iff (reset)
    normal && tdone[cpf_pkg::CH_SCC] |=>
      (s.mode == cpf_pkg::MODE_DISCH_OC) &&
      flags.load_short_fault)
    else $error("short not tripped");

  a_recover_ok: assert property (@(posedge sys_clk) // RQ4
    disable iff (reset)
    !normal && tdone[cpf_pkg::CH_REC] &&
    !tdone[cpf_pkg::CH_SCC] && !tdone[cpf_pkg::CH_OCD] |=>
      (s.mode == cpf_pkg::MODE_NORMAL))
    else $error("recovery did not restore normal");

  a_ovp_load_blind: assert property (@(posedge sys_clk) // RQ10
    disable iff (reset)
    (s.mode == cpf_pkg::MODE_OVERCHARGE) && c.cell_above_ovp |->
      !tcond[cpf_pkg::CH_OCD] && !tcond[cpf_pkg::CH_SCC])
    else $error("load detection active over threshold");

  a_tick_period: assert property (@(posedge sys_clk) // RQ21
    disable iff (reset)
    s.tick |-> tick_gap == DIV_LAST)
    else $error("tick spacing wrong");

  a_no_occ_odis: assert property (@(posedge sys_clk) // RQ18
    disable iff (reset)
    (s.mode == cpf_pkg::MODE_OVER_DISCH) |=>
      (s.mode != cpf_pkg::MODE_CHARGE_OC))
    else $error("charge overcurrent from over-discharge");

endmodule

/* cpf_cell_model.sv */
// Purpose: Cell, FETs, charger and load as the protector sees them
// Assumes: Bench drives pin voltages in mV; thresholds are plain defaults
// Notes:   Pull-up with no charger, or an open FET under load, lifts the sense pin to the cell
`timescale 1ns/1ns

module cpf_cell_model #(
  parameter int OVERCHARGE_FAULT = 4275, OVP_REL = 4175, OVER_DISCHARGE_FAULT = 2800, UVP_REL = 2900,
  parameter int INH = 1000, DISCHARGE_OVERCURRENT_FAULT = 100, LOAD_SHORT_FAULT = 500, OCC = -70
) (
  // Pin picture from the bench
  input  wire logic signed [15:0]   cell_mv,
  input  wire logic signed [15:0]   sense_mv,
  input  wire logic                 charger,
  // Protector side
  input  wire cpf_pkg::cpf_drive_t  drive,
  output var  cpf_pkg::cpf_cmp_t    cmp
);
  logic signed [15:0] v;

  // Comparator bank; a charger overpowers the weak pull-up
  always_comb begin
    v = sense_mv;
    if ((drive.sense_pullup_en && !charger) ||
        (!drive.discharge_gate_drive && sense_mv > 0))
      v = cell_mv;
    cmp.cell_above_ovp     = cell_mv > OVERCHARGE_FAULT;
    cmp.cell_above_ovp_rel = cell_mv >= OVP_REL;
    cmp.cell_below_uvp     = cell_mv < OVER_DISCHARGE_FAULT;
    cmp.cell_above_uvp_rel = cell_mv >= UVP_REL;
    cmp.cell_below_inh     = cell_mv < INH;
    cmp.sense_ge_ocd       = v >= DISCHARGE_OVERCURRENT_FAULT;
    cmp.sense_ge_scc       = v >= LOAD_SHORT_FAULT;
    cmp.sense_below_occ    = v < OCC;
    cmp.sense_far          = cell_mv - v > 1300;
    cmp.sense_below_neg    = v < -700;
    cmp.sense_le_cell_m1v  = v <= cell_mv - 1000;
  end
endmodule

/* test_cpf_fault_fsm.sv */
// Purpose: Self-checking bench for the protector fault logic
// Assumes: TICK_DIV of 4, so one delay tick is 4 clocks
// Notes:   Each trip check waits a little under and a little over its delay
`timescale 1ns/1ns

module test_cpf_fault_fsm;
  localparam int TD = 4;
  logic                sys_clk = 0, reset = 1, charger = 0;
  logic signed [15:0]  cell_mv = 3700, sense_mv = 0;
  cpf_pkg::cpf_strap_t strap = 8'h00;
  cpf_pkg::cpf_cmp_t   cmp;
  cpf_pkg::cpf_drive_t drive;
  cpf_pkg::cpf_flags_t flags;
  int                  n_mismatch = 0, comparisons = 0, cycles = 0;

  cpf_fault_fsm #(.TICK_DIV(TD)) cpf_fault_fsm_i (.sys_clk(sys_clk),
    .reset(reset), .cmp(cmp), .strap(strap), .drive(drive), .flags(flags));
  cpf_cell_model cpf_cell_model_i (.cell_mv(cell_mv), .sense_mv(sense_mv),
    .charger(charger), .drive(drive), .cmp(cmp));

  // ----------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------
  initial forever #10 sys_clk = ~sys_clk;

  // Ceiling well above the longest run, a hung timer ends here
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic run(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic pins(int c, int s, logic g);
    @(posedge sys_clk);
    cell_mv  <= 16'(c);
    sense_mv <= 16'(s);
    charger  <= g;
  endtask

  task automatic chk(string what, logic exp, logic got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Straps are only caught while reset is held
  task automatic restart(logic [7:0] s);
    @(posedge sys_clk);
    reset <= 1'b1;
    strap <= s;
    run(2);
    @(posedge sys_clk);
    reset <= 1'b0;
    run(4);
    chk("chg", 1'b1, drive.charge_gate_drive);
    chk("dsg", 1'b1, drive.discharge_gate_drive);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_short();
    pins(3700, 600, 0);
    run(4);
    chk("dsg early", 1'b1, drive.discharge_gate_drive);
    run(28);
    chk("dsg", 1'b0, drive.discharge_gate_drive);
    chk("sink", 1'b1, drive.sense_sink_en);
    chk("short", 1'b1, flags.load_short_fault);
    pins(3700, 0, 0);
    run(18 * TD);
    chk("dsg rec early", 1'b0, drive.discharge_gate_drive);
    run(40);
    chk("dsg rec", 1'b1, drive.discharge_gate_drive);
    chk("sink rec", 1'b0, drive.sense_sink_en);
  endtask

  // A dropout halfway must restart the count
  task automatic t_ocd(int lim);
    pins(3700, 150, 0);
    run(lim / 2 * TD);
    pins(3700, 0, 0);
    run(4);
    pins(3700, 150, 0);
    run((lim - 2) * TD);
    chk("dsg early", 1'b1, drive.discharge_gate_drive);
    run(2 * TD + 20);
    chk("dsg", 1'b0, drive.discharge_gate_drive);
    chk("sink", 1'b1, drive.sense_sink_en);
    chk("pull", 1'b0, drive.sense_pullup_en);
    chk("ocd", 1'b1, flags.discharge_overcurrent_fault);
    chk("no short", 1'b0, flags.load_short_fault);
    pins(3700, 0, 0);
    run(25 * TD + 20);
    chk("dsg rec", 1'b1, drive.discharge_gate_drive);
  endtask

  task automatic t_occ(int lim);
    pins(3700, -100, 1);
    run((lim - 2) * TD);
    chk("chg early", 1'b1, drive.charge_gate_drive);
    run(2 * TD + 20);
    chk("chg", 1'b0, drive.charge_gate_drive);
    chk("coc", 1'b1, flags.charge_overcurrent_fault);
    chk("dsg", 1'b1, drive.discharge_gate_drive);
    chk("pull", 1'b0, drive.sense_pullup_en);
    chk("sink", 1'b0, drive.sense_sink_en);
    pins(3700, 0, 0);
    run(25 * TD + 20);
    chk("chg rec", 1'b1, drive.charge_gate_drive);
  endtask

  task automatic t_uvp(int lim);
    pins(2700, 0, 0);
    run((lim - 2) * TD);
    chk("dsg early", 1'b1, drive.discharge_gate_drive);
    run(28);
    chk("dsg", 1'b0, drive.discharge_gate_drive);
    chk("odis", 1'b1, flags.over_discharge_fault);
    chk("pull", 1'b1, drive.sense_pullup_en);
    chk("sink", 1'b0, drive.sense_sink_en);
    chk("pdn", 1'b1, drive.power_down);
    pins(2700, -100, 1);
    run(60 * TD);
    chk("pdn chg", 1'b0, drive.power_down);
    chk("zv", 1'b1, flags.zero_volt_charging);
    chk("chg zv", 1'b1, drive.charge_gate_drive);
    pins(2850, -100, 1);
    run(30 * TD);
    chk("dsg hys", 1'b0, drive.discharge_gate_drive);
    pins(2850, -800, 1);
    run(25 * TD + 20);
    chk("dsg rec", 1'b1, drive.discharge_gate_drive);
    pins(3700, 0, 0);
    run(8);
  endtask

  task automatic t_ovp();
    pins(4300, 0, 0);
    run(2498 * TD);
    chk("chg early", 1'b1, drive.charge_gate_drive);
    run(28);
    chk("chg", 1'b0, drive.charge_gate_drive);
    chk("ovp", 1'b1, flags.overcharge_fault);
    pins(4100, -100, 1);
    run(30 * TD);
    chk("chg charger", 1'b0, drive.charge_gate_drive);
    pins(4100, 0, 0);
    run(25 * TD + 20);
    chk("chg rec", 1'b1, drive.charge_gate_drive);
  endtask

  task automatic t_inh();
    pins(500, 0, 0);
    run(8);
    chk("chg inh", 1'b0, drive.charge_gate_drive);
    pins(3700, 0, 0);
    run(8);
    chk("chg ok", 1'b1, drive.charge_gate_drive);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Main sequence; second reset picks other delay straps
  initial begin
    restart(8'h00);
    t_short();
    t_ocd(80);
    t_occ(40);
    t_uvp(200);
    t_ovp();
    t_inh();
    restart(8'h15);
    t_ocd(160);
    t_occ(60);
    t_uvp(960);
    end_of_test();
  end
endmodule
